// >>> pfwl_top.sv
// Pin function select, wake pin control and protected write lock, AHB-Lite slave
//
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module pfwl_top (
  input wire logic CLOCK_IN,
  input wire logic RSTN_IN,
  input wire logic HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [2:0] HSIZE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic HREADY_IN,
  output logic [31:0] HRDATA_OUT,
  output logic HREADYOUT_OUT,
  output logic HRESP_OUT,
  output logic [7:0] PIN_GPIO_OUT,
  output logic [7:0] PIN_ALT1_OUT,
  output logic [7:0] PIN_ALT2_OUT,
  output logic [7:0] PIN_ALT3_OUT,
  input wire logic WAKE_PIN_IN,
  output logic WAKE_PIN_OUT,
  output logic WAKE_PIN_OE_N_OUT,
  output logic WAKE_PULLUP_EN_N_OUT,
  input wire logic DEEP_PD_IN,
  output logic WAKE_REQUEST_OUT,
  output logic PROT_WRITE_EN_OUT
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release
  logic rst_s1_ff;
  logic rst_s2_ff;
  logic rst_n;

  always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end
  end
  assign rst_n = rst_s2_ff;

  ////////////////////////////////////////////////////////////////////////////
  // State
  pfwl_pkg::pfwl_state_t s_ff;
  pfwl_pkg::pfwl_state_t nxt_s;
  logic acc;
  logic key_wr;

  assign acc = HSEL_IN && HREADY_IN && (HTRANS_IN == pfwl_pkg::HTRANS_NONSEQ);
  assign key_wr = s_ff.dp_wr && (s_ff.dp_addr == pfwl_pkg::OFF_LOCK_KEY);

  always_comb begin
    nxt_s = s_ff;
    nxt_s.wake_req = 1'b0;
    // Pin and power-down level synchronisers
    nxt_s.pin_s1 = WAKE_PIN_IN;
    nxt_s.pin_s2 = s_ff.pin_s1;
    nxt_s.pd_s1 = DEEP_PD_IN;
    nxt_s.pd_s2 = s_ff.pd_s1;
    nxt_s.dp_wr = acc && HWRITE_IN;
    nxt_s.dp_addr = HADDR_IN[pfwl_pkg::ADDR_W-1:0];
    // Data phase write; no wait states
    if (s_ff.dp_wr) begin
      case (s_ff.dp_addr)
        pfwl_pkg::OFF_FUNC_SEL: begin
          nxt_s.func_sel = HWDATA_IN[pfwl_pkg::FUNC_W-1:0];
        end
        pfwl_pkg::OFF_WAKE_CTL: begin
          nxt_s.drive_lvl = HWDATA_IN[pfwl_pkg::WK_DRIVE_BIT];
          nxt_s.out_dis = HWDATA_IN[pfwl_pkg::WK_OE_BIT];
          nxt_s.pu_dis = HWDATA_IN[pfwl_pkg::WK_PU_BIT];
        end
        default: begin
        end
      endcase
      // Any other write breaks a half-done key sequence
      if (!key_wr) begin
        nxt_s.key_st = pfwl_pkg::KEY_IDLE;
      end
    end
    if (key_wr) begin
      if (s_ff.unlocked) begin
        nxt_s.unlocked = 1'b0;
        nxt_s.key_st = pfwl_pkg::KEY_IDLE;
      end else begin
        case (s_ff.key_st)
          pfwl_pkg::KEY_IDLE: begin
            if (HWDATA_IN[7:0] == pfwl_pkg::KEY_BYTE1) begin
              nxt_s.key_st = pfwl_pkg::KEY_GOT1;
            end
          end
          pfwl_pkg::KEY_GOT1: begin
            if (HWDATA_IN[7:0] == pfwl_pkg::KEY_BYTE2) begin
              nxt_s.key_st = pfwl_pkg::KEY_GOT2;
            end else begin
              nxt_s.key_st = pfwl_pkg::KEY_IDLE;
            end
          end
          pfwl_pkg::KEY_GOT2: begin
            nxt_s.key_st = pfwl_pkg::KEY_IDLE;
            if (HWDATA_IN[7:0] == pfwl_pkg::KEY_BYTE3) begin
              nxt_s.unlocked = 1'b1;
            end
          end
          default: begin
            nxt_s.key_st = pfwl_pkg::KEY_IDLE;
          end
        endcase
      end
    end
    // Pull-up setting frozen while powered down so the wake pin keeps its bias
    if (!s_ff.pd_s2) begin
      nxt_s.pu_latched = nxt_s.pu_dis;
      nxt_s.pd_level = s_ff.pin_s2;
    end else if (s_ff.pin_s2 != s_ff.pd_level) begin
      nxt_s.wake_req = 1'b1;
      nxt_s.pd_level = s_ff.pin_s2;
    end
    // Read data from the updated copy so a read right after a write sees it
    nxt_s.rdata = '0;
    if (acc && !HWRITE_IN) begin
      case (HADDR_IN[pfwl_pkg::ADDR_W-1:0])
        pfwl_pkg::OFF_FUNC_SEL: begin
          nxt_s.rdata[pfwl_pkg::FUNC_W-1:0] = nxt_s.func_sel;
        end
        pfwl_pkg::OFF_WAKE_CTL: begin
          nxt_s.rdata[pfwl_pkg::WK_DRIVE_BIT] = nxt_s.drive_lvl;
          nxt_s.rdata[pfwl_pkg::WK_OE_BIT] = nxt_s.out_dis;
          nxt_s.rdata[pfwl_pkg::WK_PU_BIT] = nxt_s.pu_dis;
          nxt_s.rdata[pfwl_pkg::WK_LEVEL_BIT] = s_ff.pin_s2;
        end
        pfwl_pkg::OFF_LOCK_KEY: begin
          nxt_s.rdata[pfwl_pkg::LOCK_STAT_BIT] = nxt_s.unlocked;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK_IN or negedge rst_n) begin
    if (!rst_n) begin
      s_ff.dp_wr <= 1'b0;
      s_ff.dp_addr <= '0;
      s_ff.rdata <= '0;
      s_ff.func_sel <= pfwl_pkg::RST_FUNC_SEL[pfwl_pkg::FUNC_W-1:0];
      s_ff.drive_lvl <= pfwl_pkg::RST_WAKE_CTL[pfwl_pkg::WK_DRIVE_BIT];
      s_ff.out_dis <= pfwl_pkg::RST_WAKE_CTL[pfwl_pkg::WK_OE_BIT];
      s_ff.pu_dis <= pfwl_pkg::RST_WAKE_CTL[pfwl_pkg::WK_PU_BIT];
      s_ff.pu_latched <= pfwl_pkg::RST_WAKE_CTL[pfwl_pkg::WK_PU_BIT];
      s_ff.pin_s1 <= 1'b0;
      s_ff.pin_s2 <= 1'b0;
      s_ff.pd_s1 <= 1'b0;
      s_ff.pd_s2 <= 1'b0;
      s_ff.pd_level <= 1'b0;
      s_ff.wake_req <= 1'b0;
      s_ff.unlocked <= pfwl_pkg::RST_LOCK_KEY[pfwl_pkg::LOCK_STAT_BIT];
      s_ff.key_st <= pfwl_pkg::KEY_IDLE;
    end else begin
      s_ff <= nxt_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign HRDATA_OUT = s_ff.rdata;
  assign HREADYOUT_OUT = 1'b1;
  assign HRESP_OUT = pfwl_pkg::HRESP_OKAY;
  assign WAKE_PIN_OUT = s_ff.drive_lvl;
  assign WAKE_PIN_OE_N_OUT = s_ff.out_dis;
  assign WAKE_PULLUP_EN_N_OUT = s_ff.pu_latched;
  assign WAKE_REQUEST_OUT = s_ff.wake_req;
  // Protected registers outside take writes only through this enable
  assign PROT_WRITE_EN_OUT = s_ff.unlocked;

  // Codes per pin: GPIO / alt1 / alt2 / alt3; pin 7 has no third function
  for (genvar i = 0; i < pfwl_pkg::PIN_N; i++) begin : g_pin
    logic [1:0] code;
    assign code = s_ff.func_sel[i*pfwl_pkg::CODE_W +: pfwl_pkg::CODE_W];
    assign PIN_GPIO_OUT[i] = (code == pfwl_pkg::CODE_GPIO);
    assign PIN_ALT1_OUT[i] = (code == pfwl_pkg::CODE_ALT1);
    assign PIN_ALT2_OUT[i] = (code == pfwl_pkg::CODE_ALT2);
    if (i == pfwl_pkg::PIN_NO_ALT3) begin : g_none
      assign PIN_ALT3_OUT[i] = 1'b0;
    end else begin : g_alt3
      assign PIN_ALT3_OUT[i] = (code == pfwl_pkg::CODE_ALT3);
    end

    // Exactly one function per pin, except the undefined code on pin 7
    property p_pin_sel;
      @(posedge CLOCK_IN) disable iff (!rst_n)
        $onehot({PIN_GPIO_OUT[i], PIN_ALT1_OUT[i], PIN_ALT2_OUT[i], PIN_ALT3_OUT[i]})
        || (i == pfwl_pkg::PIN_NO_ALT3 && code == pfwl_pkg::CODE_ALT3
          && {PIN_GPIO_OUT[i], PIN_ALT1_OUT[i], PIN_ALT2_OUT[i], PIN_ALT3_OUT[i]} == 4'h0);
    endproperty
    a_pin_sel: assert property (p_pin_sel) else $error("pin function decode wrong");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge CLOCK_IN);
  endclocking
  default disable iff (!rst_n);

  sequence s_key(logic [7:0] v);
    key_wr && (HWDATA_IN[7:0] == v);
  endsequence

  sequence s_unlock_seq;
    (!s_ff.unlocked && s_ff.key_st == pfwl_pkg::KEY_IDLE && !s_ff.dp_wr)
      ##1 s_key(pfwl_pkg::KEY_BYTE1) ##1 s_key(pfwl_pkg::KEY_BYTE2)
      ##1 s_key(pfwl_pkg::KEY_BYTE3);
  endsequence

  property p_unlock;
    s_unlock_seq |=> s_ff.unlocked;
  endproperty
  a_unlock: assert property (p_unlock) else $error("key sequence did not unlock");

  property p_bad_key;
    (!s_ff.unlocked && s_ff.key_st == pfwl_pkg::KEY_GOT1 && key_wr
      && HWDATA_IN[7:0] != pfwl_pkg::KEY_BYTE2)
      |=> s_ff.key_st == pfwl_pkg::KEY_IDLE ##1 !s_ff.unlocked;
  endproperty
  a_bad_key: assert property (p_bad_key) else $error("wrong key kept sequence");

  property p_other_wr;
    (s_ff.key_st != pfwl_pkg::KEY_IDLE && s_ff.dp_wr && !key_wr)
      |=> s_ff.key_st == pfwl_pkg::KEY_IDLE;
  endproperty
  a_other_wr: assert property (p_other_wr) else $error("other write kept sequence");

  property p_relock;
    (s_ff.unlocked && key_wr) |=> !s_ff.unlocked && !PROT_WRITE_EN_OUT;
  endproperty
  a_relock: assert property (p_relock) else $error("key write did not relock");

  property p_lock_read;
    (acc && !HWRITE_IN && HADDR_IN[11:0] == pfwl_pkg::OFF_LOCK_KEY && !key_wr)
      |=> HRDATA_OUT == {31'h0000_0000, $past(s_ff.unlocked)};
  endproperty
  a_lock_read: assert property (p_lock_read) else $error("lock status read wrong");

  property p_func_wr;
    (s_ff.dp_wr && s_ff.dp_addr == pfwl_pkg::OFF_FUNC_SEL)
      |=> s_ff.func_sel == $past(HWDATA_IN[15:0]) && PIN_GPIO_OUT[0]
        == ($past(HWDATA_IN[1:0]) == pfwl_pkg::CODE_GPIO);
  endproperty
  a_func_wr: assert property (p_func_wr) else $error("function select not stored");

  property p_wake_wr;
    (s_ff.dp_wr && s_ff.dp_addr == pfwl_pkg::OFF_WAKE_CTL)
      |=> WAKE_PIN_OE_N_OUT == $past(HWDATA_IN[2]) && WAKE_PIN_OUT == $past(HWDATA_IN[3]);
  endproperty
  a_wake_wr: assert property (p_wake_wr) else $error("wake drive not stored");

  property p_pu_hold;
    (s_ff.pd_s2 && $past(s_ff.pd_s2)) |-> $stable(WAKE_PULLUP_EN_N_OUT);
  endproperty
  a_pu_hold: assert property (p_pu_hold) else $error("pull-up changed in power down");

  property p_reserved;
    (acc && !HWRITE_IN) |=> HRDATA_OUT[31:16] == 16'h0000 && PIN_ALT3_OUT[7] == 1'b0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits not zero");

  property p_pin_read;
    (acc && !HWRITE_IN && HADDR_IN[11:0] == pfwl_pkg::OFF_WAKE_CTL)
      |=> HRDATA_OUT[0] == $past(s_ff.pin_s2);
  endproperty
  a_pin_read: assert property (p_pin_read) else $error("wake level read wrong");

  // Wake pin level moved while powered down
  sequence s_wake_edge;
    s_ff.pd_s2 && (s_ff.pin_s2 != s_ff.pd_level);
  endsequence

  // Third key byte arrives with the wrong value
  sequence s_key3_bad;
    !s_ff.unlocked && s_ff.key_st == pfwl_pkg::KEY_GOT2 && key_wr
      && HWDATA_IN[7:0] != pfwl_pkg::KEY_BYTE3;
  endsequence

  property p_wake_on_change;
    s_wake_edge |=> WAKE_REQUEST_OUT;
  endproperty
  a_wake_on_change: assert property (p_wake_on_change) else $error("no wake pulse");

  property p_wake_only_pd;
    WAKE_REQUEST_OUT |-> $past(s_ff.pd_s2);
  endproperty
  a_wake_only_pd: assert property (p_wake_only_pd) else $error("wake pulse while active");

  property p_no_wake_active;
    !s_ff.pd_s2 |=> !WAKE_REQUEST_OUT;
  endproperty
  a_no_wake_active: assert property (p_no_wake_active) else $error("stray wake pulse");

  // While awake the pin bias follows the register, updating on the same edge as the bit
  property p_pu_track;
    (!s_ff.pd_s2 && !s_ff.dp_wr) |=> WAKE_PULLUP_EN_N_OUT == $past(s_ff.pu_dis);
  endproperty
  a_pu_track: assert property (p_pu_track) else $error("pull-up not following bit");

  property p_wake_hold;
    !(s_ff.dp_wr && s_ff.dp_addr == pfwl_pkg::OFF_WAKE_CTL)
      |=> $stable(WAKE_PIN_OE_N_OUT) && $stable(WAKE_PIN_OUT);
  endproperty
  a_wake_hold: assert property (p_wake_hold) else $error("wake drive changed unasked");

  property p_fn_hold;
    !(s_ff.dp_wr && s_ff.dp_addr == pfwl_pkg::OFF_FUNC_SEL) |=> $stable(s_ff.func_sel);
  endproperty
  a_fn_hold: assert property (p_fn_hold) else $error("function select changed unasked");

  property p_key1_bad;
    (!s_ff.unlocked && s_ff.key_st == pfwl_pkg::KEY_IDLE && key_wr
      && HWDATA_IN[7:0] != pfwl_pkg::KEY_BYTE1) |=> s_ff.key_st == pfwl_pkg::KEY_IDLE;
  endproperty
  a_key1_bad: assert property (p_key1_bad) else $error("wrong first key accepted");

  property p_key3_bad;
    s_key3_bad |=> !s_ff.unlocked && s_ff.key_st == pfwl_pkg::KEY_IDLE;
  endproperty
  a_key3_bad: assert property (p_key3_bad) else $error("wrong third key unlocked");

  // Only a correct third byte may open the lock
  property p_stay_locked;
    (!s_ff.unlocked && !(s_ff.key_st == pfwl_pkg::KEY_GOT2 && key_wr)) |=> !s_ff.unlocked;
  endproperty
  a_stay_locked: assert property (p_stay_locked) else $error("unlocked without sequence");

  // Read data stands one cycle only, so a stale value cannot be mistaken for a read
  property p_rdata_idle;
    !(acc && !HWRITE_IN) |=> HRDATA_OUT == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside data phase");

endmodule
`default_nettype wire

// >>> pfwl_pkg.sv
// Shared constants and types for the pin function, wake pin and write lock block
package pfwl_pkg;
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFF_FUNC_SEL = 12'h03C;
  localparam logic [11:0] OFF_WAKE_CTL = 12'h054;
  localparam logic [11:0] OFF_LOCK_KEY = 12'h100;
  localparam logic [31:0] RST_FUNC_SEL = 32'h0000_0000;
  localparam logic [31:0] RST_WAKE_CTL = 32'h0000_0006;
  localparam logic [31:0] RST_LOCK_KEY = 32'h0000_0000;
  localparam int FUNC_W = 16;
  localparam int PIN_N = 8;
  localparam int CODE_W = 2;
  localparam logic [1:0] CODE_GPIO = 2'h0;
  localparam logic [1:0] CODE_ALT1 = 2'h1;
  localparam logic [1:0] CODE_ALT2 = 2'h2;
  localparam logic [1:0] CODE_ALT3 = 2'h3;
  localparam int PIN_NO_ALT3 = 7;
  localparam int WK_LEVEL_BIT = 0;
  localparam int WK_PU_BIT = 1;
  localparam int WK_OE_BIT = 2;
  localparam int WK_DRIVE_BIT = 3;
  localparam int LOCK_STAT_BIT = 0;
  localparam logic [7:0] KEY_BYTE1 = 8'h59;
  localparam logic [7:0] KEY_BYTE2 = 8'h16;
  localparam logic [7:0] KEY_BYTE3 = 8'h88;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic [1:0] {
    KEY_IDLE,
    KEY_GOT1,
    KEY_GOT2
  } pfwl_key_t;

  typedef struct packed {
    logic dp_wr;
    logic [11:0] dp_addr;
    logic [31:0] rdata;
    logic [15:0] func_sel;
    logic drive_lvl;
    logic out_dis;
    logic pu_dis;
    logic pu_latched;
    logic pin_s1;
    logic pin_s2;
    logic pd_s1;
    logic pd_s2;
    logic pd_level;
    logic wake_req;
    logic unlocked;
    pfwl_key_t key_st;
  } pfwl_state_t;
endpackage

// >>> pfwl_wake_model.sv
// Model of the board circuitry on the wake pin: resolves the wire level
`timescale 1ns/10ps
`default_nettype none
module pfwl_wake_model (
  input wire logic clk_in,
  input wire logic drive_in,
  input wire logic oe_n_in,
  input wire logic pu_n_in,
  input wire logic ext_en_in,
  input wire logic ext_lvl_in,
  output logic pin_out
);
  logic last_ff = 1'b0;
  ////////////////////////////////////////////////////////////////////////////////
  // Device drive wins, then the outside driver, then the pull-up
  always_comb begin
    if (!oe_n_in) begin
      pin_out = drive_in;
    end else if (ext_en_in) begin
      pin_out = ext_lvl_in;
    end else if (!pu_n_in) begin
      pin_out = 1'b1;
    end else begin
      // A floating pin must not look like a stable level
      pin_out = ~last_ff;
    end
  end
  always_ff @(posedge clk_in) begin
    last_ff <= pin_out;
  end
endmodule
`default_nettype wire

// >>> pfwl_top_tb.sv
// Self-checking bench for the pin function, wake pin and write lock block
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin miscompares++; \
  $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module pfwl_top_tb;
  localparam logic [31:0] A_FN = 32'h0000_003C;
  localparam logic [31:0] A_WK = 32'h0000_0054;
  localparam logic [31:0] A_KEY = 32'h0000_0100;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic hready, hresp, wk_out, wk_oe_n, wk_pu_n, wk_pin, wk_req, prot;
  logic [7:0] gpio, alt1, alt2, alt3;
  logic deep_pd = 1'b0;
  logic ext_en = 1'b1;
  logic ext_lvl = 1'b0;
  int miscompares = 0;
  int check_count = 0;
  ////////////////////////////////////////////////////////////////////////////////
  pfwl_top i_dut (.CLOCK_IN(clk), .RSTN_IN(rstn), .HSEL_IN(hsel), .HADDR_IN(haddr),
    .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata),
    .HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
    .PIN_GPIO_OUT(gpio), .PIN_ALT1_OUT(alt1), .PIN_ALT2_OUT(alt2), .PIN_ALT3_OUT(alt3),
    .WAKE_PIN_IN(wk_pin), .WAKE_PIN_OUT(wk_out), .WAKE_PIN_OE_N_OUT(wk_oe_n),
    .WAKE_PULLUP_EN_N_OUT(wk_pu_n), .DEEP_PD_IN(deep_pd), .WAKE_REQUEST_OUT(wk_req),
    .PROT_WRITE_EN_OUT(prot));
  pfwl_wake_model i_wake (.clk_in(clk), .drive_in(wk_out), .oe_n_in(wk_oe_n),
    .pu_n_in(wk_pu_n), .ext_en_in(ext_en), .ext_lvl_in(ext_lvl), .pin_out(wk_pin));
  initial begin
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Bounded wait for hready sampled high at a rising edge
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 20);
    if (hready !== 1'b1) begin
      miscompares++;
      tally_and_finish();
    end
  endtask
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= pfwl_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
    @(posedge clk);
  endtask
  // Gap first so the two-stage pin synchroniser settles
  task automatic rdchk(input logic [31:0] a, input logic [31:0] e, input string nm);
    repeat (3) @(posedge clk);
    xfer(a, 1'b0, 32'h0);
    `CHK(nm, e, rd)
  endtask
  task automatic keys(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
    wr(A_KEY, {24'h0, a});
    wr(A_KEY, {24'h0, b});
    wr(A_KEY, {24'h0, c});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rdchk(A_FN, 32'h0, "func_sel");
    rdchk(A_WK, 32'h6, "wake_ctl");
    rdchk(A_KEY, 32'h0, "lock_key");
    rdchk(32'h0000_0080, 32'h0, "unmapped");
    `CHK("gpio", 8'hFF, gpio)
    `CHK("prot", 1'b0, prot)
    $display("test reset done");
  endtask
  task automatic t_func;
    logic [15:0] f;
    for (int c = 0; c < 4; c++) begin
      f = {8{c[1:0]}};
      wr(A_FN, {16'hFFFF, f});
      rdchk(A_FN, {16'h0, f}, "func_sel");
      `CHK("gpio", (c == 0) ? 8'hFF : 8'h00, gpio)
      `CHK("alt1", (c == 1) ? 8'hFF : 8'h00, alt1)
      `CHK("alt2", (c == 2) ? 8'hFF : 8'h00, alt2)
      `CHK("alt3", (c == 3) ? 8'h7F : 8'h00, alt3)
    end
    // Pins 3..0 and 7..4 carry codes 3,2,1,0 to pin down each field
    wr(A_FN, 32'h0000_E4E4);
    `CHK("gpio", 8'h11, gpio)
    `CHK("alt1", 8'h22, alt1)
    `CHK("alt2", 8'h44, alt2)
    `CHK("alt3", 8'h08, alt3)
    $display("test function select done");
  endtask
  task automatic t_wake;
    @(posedge clk);
    ext_en <= 1'b0;
    wr(A_WK, 32'h8);
    `CHK("oe_n", 1'b0, wk_oe_n)
    rdchk(A_WK, 32'h9, "wake_high");
    wr(A_WK, 32'h1);
    rdchk(A_WK, 32'h0, "wake_low");
    wr(A_WK, 32'h4);
    `CHK("pu_n", 1'b0, wk_pu_n)
    rdchk(A_WK, 32'h5, "wake_pullup");
    @(posedge clk);
    ext_en <= 1'b1;
    wr(A_WK, 32'hFFFF_FFFE);
    rdchk(A_WK, 32'hE, "wake_rsvd");
    $display("test wake pin done");
  endtask
  task automatic t_pd;
    int n;
    n = 0;
    wr(A_WK, 32'h4);
    @(posedge clk);
    deep_pd <= 1'b1;
    repeat (4) @(posedge clk);
    wr(A_WK, 32'h6);
    `CHK("pu_latched", 1'b0, wk_pu_n)
    @(posedge clk);
    ext_lvl <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      if (wk_req === 1'b1) n++;
    end
    `CHK("wake_pulses", 1, n)
    deep_pd <= 1'b0;
    ext_lvl <= 1'b0;
    $display("test power down done");
  endtask
  task automatic t_lock;
    keys(8'h59, 8'h16, 8'h88);
    rdchk(A_KEY, 32'h1, "unlocked");
    `CHK("prot", 1'b1, prot)
    wr(A_KEY, 32'h0000_0059);
    rdchk(A_KEY, 32'h0, "relocked");
    `CHK("prot", 1'b0, prot)
    keys(8'h16, 8'h59, 8'h88);
    rdchk(A_KEY, 32'h0, "order");
    keys(8'h59, 8'h17, 8'h88);
    rdchk(A_KEY, 32'h0, "value");
    wr(A_KEY, 32'h0000_0059);
    wr(A_FN, 32'h0);
    keys(8'h16, 8'h88, 8'h00);
    rdchk(A_KEY, 32'h0, "other_addr");
    keys(8'h59, 8'h16, 8'h88);
    rdchk(A_KEY, 32'h1, "unlocked2");
    $display("test lock done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_func();
    t_wake();
    t_pd();
    t_lock();
    tally_and_finish();
  end
endmodule
`default_nettype wire
